// ### src/twcs_pkg.sv
// shared constants and carriers of the two-wire clock and status block
// assumes a 32-bit register port and one peripheral clock
package twcs_pkg;

  // register byte addresses
  localparam logic [31:0] A_MODE = 32'h400a8004;
  localparam logic [31:0] A_OWN_SLAVE_ADDRESS = 32'h400a8008;
  localparam logic [31:0] A_SLAVE_INTERNAL_ADDRESS = 32'h400a800c;
  localparam logic [31:0] A_CWGR = 32'h400a8010;
  localparam logic [31:0] A_SR = 32'h400a8020;
  localparam logic [31:0] A_IMASK = 32'h400a802c;
  localparam logic [31:0] A_RHR = 32'h400a8030;
  localparam logic [31:0] A_THR = 32'h400a8034;
  localparam logic [31:0] A_WPMR = 32'h400a80e4;
  localparam logic [31:0] A_RCR = 32'h400a8104;
  localparam logic [31:0] A_TCR = 32'h400a810c;
  localparam logic [31:0] A_RNCR = 32'h400a8114;
  localparam logic [31:0] A_TNCR = 32'h400a811c;

  // field positions
  localparam int P_MASTER_ENABLE = 0;
  localparam int P_SLEN = 1;
  localparam int P_IASZ = 8;
  localparam int P_OWN_SLAVE_ADDRESS = 16;
  localparam int P_SCL_PRESCALE_EXPONENT = 16;
  localparam int P_SCL_HIGH_DIVIDER = 8;
  localparam int P_SCL_LOW_DIVIDER = 0;
  localparam int P_WRITE_PROTECT_ENABLE = 0;
  localparam int P_WRITE_PROTECT_KEY = 8;

  // reset values and fixed figures
  localparam logic [15:0] SR_RESET = 16'hf009;
  localparam logic [23:0] WP_KEY = 24'h545749;
  localparam logic [15:0] SCL_EXTRA = 16'h0004;
  localparam logic [1:0] IASZ_NONE = 2'h0;

  // status bits 15..0
  typedef struct packed {
    logic transmit_buffer_empty;
    logic receive_buffer_full;
    logic end_of_transmit;
    logic end_of_receive;
    logic end_of_slave_access;
    logic clock_wait_state;
    logic arbitration_lost;
    logic not_ack;
    logic unused7;
    logic receive_overrun;
    logic general_call_seen;
    logic slave_access;
    logic slave_read_direction;
    logic transmit_ready;
    logic receive_ready;
    logic transfer_complete;
  } twcs_sr_t;

  // pulses and levels from the byte/protocol engine
  typedef struct packed {
    logic start_seen;
    logic stop_seen;
    logic rstart_nomatch;
    logic addr_match;
    logic addr_read;
    logic gen_call;
    logic rx_load;
    logic [7:0] rx_data;
    logic tx_taken;
    logic tx_acked;
    logic nack_seen;
    logic arb_lost;
    logic stop_sent;
    logic char_due;
    logic scl_run;
  } twcs_ev_t;

  // transmit byte toward the engine
  typedef struct packed {
    logic valid;
    logic halt;
    logic [7:0] data;
  } twcs_tx_t;

  // whole state of the block
  typedef struct packed {
    twcs_sr_t sr;
    twcs_tx_t tx;
    logic master_enable;
    logic slen;
    logic [1:0] iasz;
    logic [6:0] own_slave_address;
    logic [23:0] slave_internal_address;
    logic [23:0] ia;
    logic [2:0] scl_prescale_exponent;
    logic [7:0] scl_high_divider;
    logic [7:0] scl_low_divider;
    logic write_protect_enable;
    logic [15:0] imask;
    logic [7:0] rhr;
    logic [15:0] rcr;
    logic [15:0] rncr;
    logic [15:0] tcr;
    logic [15:0] tncr;
    logic [31:0] rdata;
    logic scl_high;
    logic [15:0] scl_cnt;
    logic scl_oe;
    logic scl_out;
    logic irq;
  } twcs_st_t;

endpackage

// ### src/twcs_top.sv
// scl waveform generator, status flags and register port of the two-wire controller
// assumes a byte engine beside it that reports bus events as one-cycle pulses
// Behaviour
// R01 - internal address uses zero to three bytes
// R02 - size field: 0 none, 1..3 bytes
// R03 - waveform register locked by write protect
// R04 - protect bit changes only with right key
// R05 - scl low: low divider scaled plus four
// R06 - scl high: high divider scaled plus four
// R07 - master: complete low in frame, set after stop
// R08 - slave: complete cleared on start, set on stop
// R09 - receive ready set on load, read clears
// R10 - master transmit ready: write clears, events set
// R11 - slave transmit ready set after acknowledged byte
// R12 - slave stops sending after nack with ready
// R13 - slave reports access direction
// R14 - slave access held until nack or stop
// R15 - general call flag, cleared by status read
// R16 - master: overrun on reload while ready, cleared conditionally
// R17 - master nack flag with transfer complete
// R18 - slave write acks all; slave read nack
// R19 - arbitration lost flag with transfer complete
// R20 - slave stretches scl when buffer not serviced
// R21 - end of slave access when access falls
// R22 - end flags at zero count, cleared by rewrite
// R23 - buffer full/empty when both counts zero
// R24 - interrupt when enabled flag set
//
// Chosen here: the strobed register port.
`timescale 1ns/10ps
module twcs_top (
  // clock and reset
  input wire logic i_mclk,
  input wire logic i_rst_n,
  // register port
  input wire logic [31:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [31:0] o_rdata,
  // scl pin
  input wire logic i_scl,
  output logic o_scl_out,
  output logic o_scl_oe,
  // byte engine
  input wire twcs_pkg::twcs_ev_t i_ev,
  output twcs_pkg::twcs_tx_t o_tx,
  output logic [23:0] o_int_addr,
  output logic [1:0] o_int_addr_size,
  output logic [6:0] o_own_addr,
  output logic o_master_en,
  output logic o_slave_en,
  // interrupt request
  output logic o_irq
);

  twcs_pkg::twcs_st_t q;
  twcs_pkg::twcs_st_t next_q;

  // one scl phase length in clock cycles
  function automatic logic [15:0] phase_len(input logic [7:0] div, input logic [2:0] ex);
    phase_len = ({8'h00, div} << ex) + twcs_pkg::SCL_EXTRA;
  endfunction

  always_comb
  begin
    next_q = q;
    next_q.rdata = 32'h00000000;
    // register writes
    if (i_wr)
    begin
      case (i_addr)
        twcs_pkg::A_MODE:
        begin
          next_q.master_enable = i_wdata[twcs_pkg::P_MASTER_ENABLE];
          next_q.slen = i_wdata[twcs_pkg::P_SLEN];
          next_q.iasz = i_wdata[twcs_pkg::P_IASZ +: 2]; // [R02]
          if (i_wdata[twcs_pkg::P_MASTER_ENABLE] && !q.master_enable)
          begin
            next_q.sr.transmit_ready = 1'b1; // [R10]
          end
        end
        twcs_pkg::A_OWN_SLAVE_ADDRESS: next_q.own_slave_address = i_wdata[twcs_pkg::P_OWN_SLAVE_ADDRESS +: 7];
        twcs_pkg::A_SLAVE_INTERNAL_ADDRESS: next_q.slave_internal_address = i_wdata[23:0];
        twcs_pkg::A_CWGR:
        begin
          if (!q.write_protect_enable)
          begin
            next_q.scl_prescale_exponent = i_wdata[twcs_pkg::P_SCL_PRESCALE_EXPONENT +: 3]; // [R03]
            next_q.scl_high_divider = i_wdata[twcs_pkg::P_SCL_HIGH_DIVIDER +: 8];
            next_q.scl_low_divider = i_wdata[twcs_pkg::P_SCL_LOW_DIVIDER +: 8];
          end
        end
        twcs_pkg::A_IMASK: next_q.imask = i_wdata[15:0];
        twcs_pkg::A_THR:
        begin
          next_q.tx.data = i_wdata[7:0];
          next_q.tx.valid = 1'b1;
          next_q.sr.transmit_ready = 1'b0; // [R10] [R11]
        end
        twcs_pkg::A_WPMR:
        begin
          if (i_wdata[twcs_pkg::P_WRITE_PROTECT_KEY +: 24] == twcs_pkg::WP_KEY)
          begin
            next_q.write_protect_enable = i_wdata[twcs_pkg::P_WRITE_PROTECT_ENABLE]; // [R04]
          end
        end
        twcs_pkg::A_RCR:
        begin
          next_q.rcr = i_wdata[15:0];
          next_q.sr.end_of_receive = 1'b0; // [R22]
        end
        twcs_pkg::A_RNCR:
        begin
          next_q.rncr = i_wdata[15:0];
          next_q.sr.end_of_receive = 1'b0; // [R22]
        end
        twcs_pkg::A_TCR:
        begin
          next_q.tcr = i_wdata[15:0];
          next_q.sr.end_of_transmit = 1'b0; // [R22]
        end
        twcs_pkg::A_TNCR:
        begin
          next_q.tncr = i_wdata[15:0];
          next_q.sr.end_of_transmit = 1'b0; // [R22]
        end
        default: ;
      endcase
    end
    // register reads and their side effects
    if (i_rd)
    begin
      case (i_addr)
        twcs_pkg::A_MODE:
          next_q.rdata = (32'(q.iasz) << twcs_pkg::P_IASZ) | (32'(q.slen) << twcs_pkg::P_SLEN)
                         | (32'(q.master_enable) << twcs_pkg::P_MASTER_ENABLE);
        twcs_pkg::A_OWN_SLAVE_ADDRESS: next_q.rdata = 32'(q.own_slave_address) << twcs_pkg::P_OWN_SLAVE_ADDRESS;
        twcs_pkg::A_SLAVE_INTERNAL_ADDRESS: next_q.rdata = {8'h00, q.slave_internal_address};
        twcs_pkg::A_CWGR:
          next_q.rdata = (32'(q.scl_prescale_exponent) << twcs_pkg::P_SCL_PRESCALE_EXPONENT) | (32'(q.scl_high_divider) << twcs_pkg::P_SCL_HIGH_DIVIDER)
                         | (32'(q.scl_low_divider) << twcs_pkg::P_SCL_LOW_DIVIDER);
        twcs_pkg::A_SR:
        begin
          next_q.rdata = {16'h0000, q.sr};
          next_q.sr.general_call_seen = 1'b0; // [R15]
          next_q.sr.not_ack = 1'b0; // [R17]
          next_q.sr.arbitration_lost = 1'b0; // [R19]
          next_q.sr.end_of_slave_access = 1'b0; // [R21]
          if (q.sr.transfer_complete)
          begin
            next_q.sr.receive_overrun = 1'b0; // [R16]
          end
        end
        twcs_pkg::A_IMASK: next_q.rdata = {16'h0000, q.imask};
        twcs_pkg::A_RHR:
        begin
          next_q.rdata = {24'h000000, q.rhr};
          next_q.sr.receive_ready = 1'b0; // [R09]
        end
        twcs_pkg::A_WPMR: next_q.rdata = 32'(q.write_protect_enable) << twcs_pkg::P_WRITE_PROTECT_ENABLE;
        twcs_pkg::A_RCR: next_q.rdata = {16'h0000, q.rcr};
        twcs_pkg::A_RNCR: next_q.rdata = {16'h0000, q.rncr};
        twcs_pkg::A_TCR: next_q.rdata = {16'h0000, q.tcr};
        twcs_pkg::A_TNCR: next_q.rdata = {16'h0000, q.tncr};
        default: next_q.rdata = 32'h00000000;
      endcase
    end
    // engine events; sets come after clears so they win
    if (i_ev.tx_taken || i_ev.tx_acked)
    begin
      if (!(i_wr && i_addr == twcs_pkg::A_THR))
      begin
        next_q.tx.valid = 1'b0;
      end
    end
    if (i_ev.rx_load)
    begin
      next_q.rhr = i_ev.rx_data;
      next_q.sr.receive_ready = 1'b1; // [R09]
    end
    if (q.master_enable)
    begin
      if (i_ev.start_seen)
      begin
        next_q.sr.transfer_complete = 1'b0; // [R07]
      end
      if (i_ev.stop_sent)
      begin
        next_q.sr.transfer_complete = 1'b1; // [R07]
      end
      if (i_ev.tx_taken)
      begin
        next_q.sr.transmit_ready = 1'b1; // [R10]
      end
      if (i_ev.nack_seen)
      begin
        next_q.sr.not_ack = 1'b1; // [R17]
        next_q.sr.transfer_complete = 1'b1; // [R17]
        next_q.sr.transmit_ready = 1'b1; // [R10]
      end
      if (i_ev.arb_lost)
      begin
        next_q.sr.arbitration_lost = 1'b1; // [R19]
        next_q.sr.transfer_complete = 1'b1; // [R19]
      end
      if (i_ev.rx_load && q.sr.receive_ready)
      begin
        next_q.sr.receive_overrun = 1'b1; // [R16]
      end
    end
    if (q.slen)
    begin
      if (i_ev.start_seen)
      begin
        next_q.sr.transfer_complete = 1'b0; // [R08]
        next_q.tx.halt = 1'b0;
      end
      if (i_ev.stop_seen || i_ev.rstart_nomatch)
      begin
        next_q.sr.transfer_complete = 1'b1; // [R08]
      end
      if (i_ev.nack_seen || i_ev.stop_seen)
      begin
        next_q.sr.slave_access = 1'b0; // [R14]
      end
      if (i_ev.addr_match)
      begin
        next_q.sr.slave_access = 1'b1; // [R14]
        next_q.sr.slave_read_direction = i_ev.addr_read; // [R13]
      end
      if (i_ev.gen_call)
      begin
        next_q.sr.general_call_seen = 1'b1; // [R15]
      end
      if (i_ev.tx_acked)
      begin
        next_q.sr.transmit_ready = 1'b1; // [R11]
      end
      // writes are always acked by the engine, so only reads raise nack
      if (i_ev.nack_seen && q.sr.slave_read_direction)
      begin
        next_q.sr.not_ack = 1'b1; // [R18]
      end
      if (i_ev.nack_seen && q.sr.transmit_ready)
      begin
        next_q.tx.halt = 1'b1; // [R12]
      end
      if (q.sr.slave_access && !next_q.sr.slave_access)
      begin
        next_q.sr.end_of_slave_access = 1'b1; // [R21]
      end
      next_q.sr.clock_wait_state = next_q.sr.slave_access && i_ev.char_due
        && (next_q.sr.slave_read_direction ? next_q.sr.transmit_ready
                                           : next_q.sr.receive_ready); // [R20]
    end
    else
    begin
      next_q.sr.clock_wait_state = 1'b0;
    end
    // transfer counts with chaining of the next count
    if (i_ev.rx_load && next_q.rcr != 16'h0000)
    begin
      next_q.rcr = next_q.rcr - 16'h0001;
      if (next_q.rcr == 16'h0000)
      begin
        next_q.sr.end_of_receive = 1'b1; // [R22]
        next_q.rcr = next_q.rncr;
        next_q.rncr = 16'h0000;
      end
    end
    if ((i_ev.tx_taken || i_ev.tx_acked) && next_q.tcr != 16'h0000)
    begin
      next_q.tcr = next_q.tcr - 16'h0001;
      if (next_q.tcr == 16'h0000)
      begin
        next_q.sr.end_of_transmit = 1'b1; // [R22]
        next_q.tcr = next_q.tncr;
        next_q.tncr = 16'h0000;
      end
    end
    next_q.sr.receive_buffer_full = (next_q.rcr == 16'h0000) && (next_q.rncr == 16'h0000); // [R23]
    next_q.sr.transmit_buffer_empty = (next_q.tcr == 16'h0000)
                                      && (next_q.tncr == 16'h0000); // [R23]
    next_q.sr.unused7 = 1'b0;
    // internal address trimmed to the selected size
    next_q.ia = next_q.slave_internal_address & ~(24'hffffff << {next_q.iasz, 3'b000}); // [R01]
    // scl waveform; a high phase waits while another party holds scl low
    if (!(next_q.master_enable && i_ev.scl_run))
    begin
      next_q.scl_high = 1'b1;
      next_q.scl_cnt = phase_len(next_q.scl_high_divider, next_q.scl_prescale_exponent);
    end
    else if (!q.scl_high || i_scl)
    begin
      if (q.scl_cnt == 16'h0001)
      begin
        next_q.scl_high = !q.scl_high;
        next_q.scl_cnt = q.scl_high ? phase_len(q.scl_low_divider, q.scl_prescale_exponent)
                                    : phase_len(q.scl_high_divider, q.scl_prescale_exponent); // [R05] [R06]
      end
      else
      begin
        next_q.scl_cnt = q.scl_cnt - 16'h0001;
      end
    end
    next_q.scl_oe = (next_q.master_enable && i_ev.scl_run && !next_q.scl_high)
                    || next_q.sr.clock_wait_state; // [R20]
    next_q.scl_out = 1'b0;
    next_q.irq = |(next_q.sr & next_q.imask); // [R24]
  end

  always_ff @(posedge i_mclk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      q <= '0;
      q.sr <= twcs_pkg::SR_RESET;
      q.scl_high <= 1'b1;
      q.scl_cnt <= twcs_pkg::SCL_EXTRA;
    end
    else
    begin
      q <= next_q;
    end
  end

  assign o_rdata = q.rdata;
  assign o_scl_out = q.scl_out;
  assign o_scl_oe = q.scl_oe;
  assign o_tx = q.tx;
  assign o_int_addr = q.ia;
  assign o_int_addr_size = q.iasz;
  assign o_own_addr = q.own_slave_address;
  assign o_master_en = q.master_enable;
  assign o_slave_en = q.slen;
  assign o_irq = q.irq;

  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (!i_rst_n);

  wp_block_a: assert property ( // [R03]
    (i_wr && i_addr == twcs_pkg::A_CWGR && q.write_protect_enable) |=> $stable({q.scl_prescale_exponent, q.scl_high_divider, q.scl_low_divider}))
    else $error("waveform register changed while protected");

  wp_key_a: assert property ( // [R04]
    (i_wr && i_addr == twcs_pkg::A_WPMR && i_wdata[31:8] != twcs_pkg::WP_KEY) |=> $stable(q.write_protect_enable))
    else $error("protect bit changed with wrong key");

  rx_ready_a: assert property ( // [R09]
    i_ev.rx_load |=> q.sr.receive_ready && q.rhr == $past(i_ev.rx_data))
    else $error("received byte not flagged");

  receive_overrun_set_a: assert property ( // [R16]
    (q.master_enable && i_ev.rx_load && q.sr.receive_ready) |=> q.sr.receive_overrun)
    else $error("overrun missed");

  nack_master_a: assert property ( // [R17]
    (q.master_enable && i_ev.nack_seen) |=> q.sr.not_ack && q.sr.transfer_complete && q.sr.transmit_ready)
    else $error("master nack flags wrong");

  arb_lost_a: assert property ( // [R19]
    (q.master_enable && i_ev.arb_lost) |=> q.sr.arbitration_lost && q.sr.transfer_complete)
    else $error("arbitration loss not flagged");

  gen_call_a: assert property ( // [R15]
    (q.slen && i_ev.gen_call) |=> q.sr.general_call_seen)
    else $error("general call not flagged");

  eos_access_a: assert property ( // [R21]
    (q.slen && $fell(q.sr.slave_access)) |-> q.sr.end_of_slave_access)
    else $error("end of slave access missing");

  ia_none_a: assert property ( // [R01]
    (q.iasz == twcs_pkg::IASZ_NONE && $stable(q.iasz) && $stable(q.slave_internal_address)) |-> q.ia == 24'h000000)
    else $error("internal address not trimmed");

  irq_track_a: assert property ( // [R24]
    ##1 (o_irq == |($past(q.sr) & $past(q.imask)) || $changed(q.sr) || $changed(q.imask)))
    else $error("interrupt does not follow flags");

endmodule

// ### dv/twcs_far_end.sv
// far-end model: byte engine events and the scl wire beyond the block
// assumes scl has a pull-up and the bench launches events through pulse
`timescale 1ns/10ps
module twcs_far_end (
  // clock
  input wire logic i_mclk,
  // scl pin of the block
  input wire logic i_scl_out,
  input wire logic i_scl_oe,
  // toward the block
  output logic o_scl,
  output twcs_pkg::twcs_ev_t o_ev
);
  twcs_pkg::twcs_ev_t pl;
  logic run;
  logic due;

  initial
  begin
    pl = '0;
    run = 1'b0;
    due = 1'b0;
  end

  // wired-and with pull-up: a released wire reads high
  assign o_scl = !(i_scl_oe && !i_scl_out);

  // levels ride beside the one-cycle pulses
  always_comb
  begin
    o_ev = pl;
    o_ev.scl_run = run;
    o_ev.char_due = due;
  end

  // one-cycle event; data fields only valid with their pulse
  task automatic pulse(input twcs_pkg::twcs_ev_t e);
    @(posedge i_mclk);
    pl <= e;
    @(posedge i_mclk);
    pl <= '0;
  endtask
endmodule

// ### dv/twcs_top_tb.sv
// self-checking bench of the two-wire clock and status block
// assumes the far-end model supplies engine events and the scl wire
`timescale 1ns/10ps
module twcs_top_tb;
  logic i_mclk;
  logic i_rst_n;
  logic [31:0] addr;
  logic [31:0] wdata;
  logic wr;
  logic rd;
  logic [31:0] rdata;
  logic scl;
  logic scl_out;
  logic scl_oe;
  twcs_pkg::twcs_ev_t ev_in;
  twcs_pkg::twcs_tx_t tx;
  logic [23:0] int_addr;
  logic [1:0] int_size;
  logic irq;
  logic [6:0] own;
  logic men;
  logic sen;
  logic [31:0] d;
  twcs_pkg::twcs_sr_t s;
  int n_errors = 0;
  int num_checks = 0;

  twcs_top dut (.i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_addr(addr), .i_wdata(wdata),
    .i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_scl(scl), .o_scl_out(scl_out),
    .o_scl_oe(scl_oe), .i_ev(ev_in), .o_tx(tx), .o_int_addr(int_addr),
    .o_int_addr_size(int_size), .o_own_addr(own), .o_master_en(men), .o_slave_en(sen),
    .o_irq(irq));
  twcs_far_end far (.i_mclk(i_mclk), .i_scl_out(scl_out), .i_scl_oe(scl_oe), .o_scl(scl),
    .o_ev(ev_in));

  initial
  begin
    i_mclk = 1'b0;
    forever #10 i_mclk = ~i_mclk;
  end

  task automatic chk32(input string n, input logic [31:0] e, input logic [31:0] g);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", n, e, g);
    end
  endtask

  task automatic chk1(input string n, input logic e, input logic g);
    chk32(n, {31'h0, e}, {31'h0, g});
  endtask

  task automatic wr_reg(input logic [31:0] a, input logic [31:0] v);
    @(posedge i_mclk);
    addr <= a;
    wdata <= v;
    wr <= 1'b1;
    @(posedge i_mclk);
    wr <= 1'b0;
    #1;
  endtask

  // data stand only in the cycle after the strobe
  task automatic rd_reg(input logic [31:0] a);
    @(posedge i_mclk);
    addr <= a;
    rd <= 1'b1;
    @(posedge i_mclk);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic get_sr;
    rd_reg(twcs_pkg::A_SR);
    s = twcs_pkg::twcs_sr_t'(d[15:0]);
  endtask

  task automatic ev(input string k, input logic [7:0] v = 8'h00);
    twcs_pkg::twcs_ev_t e;
    e = '0;
    case (k)
      "st": e.start_seen = 1'b1;
      "sp": e.stop_seen = 1'b1;
      "mr": {e.addr_match, e.addr_read} = 2'b11;
      "mw": e.addr_match = 1'b1;
      "gc": e.gen_call = 1'b1;
      "ld": {e.rx_load, e.rx_data} = {1'b1, v};
      "tk": e.tx_taken = 1'b1;
      "ak": e.tx_acked = 1'b1;
      "nk": e.nack_seen = 1'b1;
      "ab": e.arb_lost = 1'b1;
      "rn": e.rstart_nomatch = 1'b1;
      default: e.stop_sent = 1'b1;
    endcase
    far.pulse(e);
  endtask

  // length, from now, of the current or next phase with scl_oe at level v
  task automatic span(input logic v, output int n);
    n = 0;
    for (int i = 0; i < 200 && scl_oe !== v; i++) @(posedge i_mclk) #1;
    while (n < 200 && scl_oe === v)
    begin
      @(posedge i_mclk);
      #1;
      n++;
    end
  endtask

  task automatic fin(input string n);
    $display("test %s finished, %0d mismatches so far", n, n_errors);
  endtask

  task automatic test_done;
    $display("checks %0d, mismatches %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  task automatic t_reset;
    rd_reg(twcs_pkg::A_SR);
    chk32("status reset", 32'h0000f009, d);
    rd_reg(twcs_pkg::A_CWGR);
    chk32("waveform reset", 32'h0, d);
    rd_reg(32'h400a8000);
    chk32("unmapped read", 32'h0, d);
    chk1("scl drive reset", 1'b0, scl_oe);
    fin("reset");
  endtask

  task automatic t_protect;
    wr_reg(twcs_pkg::A_CWGR, 32'h00010203);
    rd_reg(twcs_pkg::A_CWGR);
    chk32("waveform write", 32'h00010203, d);
    wr_reg(twcs_pkg::A_WPMR, 32'h00000001);
    wr_reg(twcs_pkg::A_CWGR, 32'h00000505);
    rd_reg(twcs_pkg::A_CWGR);
    chk32("wrong key", 32'h00000505, d);
    wr_reg(twcs_pkg::A_WPMR, {twcs_pkg::WP_KEY, 8'h01});
    wr_reg(twcs_pkg::A_CWGR, 32'h00010203);
    rd_reg(twcs_pkg::A_CWGR);
    chk32("locked write", 32'h00000505, d);
    wr_reg(twcs_pkg::A_WPMR, {twcs_pkg::WP_KEY, 8'h00});
    wr_reg(twcs_pkg::A_CWGR, 32'h00010203);
    rd_reg(twcs_pkg::A_CWGR);
    chk32("unlocked write", 32'h00010203, d);
    fin("protect");
  endtask

  task automatic t_scl;
    int hi;
    int lo;
    wr_reg(twcs_pkg::A_MODE, 32'h1);
    get_sr;
    chk1("ready on enable", 1'b1, s.transmit_ready);
    far.run <= 1'b1;
    span(1'b1, lo);
    span(1'b0, hi);
    span(1'b1, lo);
    chk32("scl high", (32'h2 << 1) + 32'h4, hi);
    chk32("scl low", (32'h3 << 1) + 32'h4, lo);
    far.run <= 1'b0;
    fin("scl");
  endtask

  task automatic t_master;
    wr_reg(twcs_pkg::A_THR, 32'h55);
    chk32("tx byte", 32'h155, {23'h0, tx.valid, tx.data});
    ev("st");
    get_sr;
    chk1("ready after write", 1'b0, s.transmit_ready);
    ev("tk");
    get_sr;
    chk1("ready after move", 1'b1, s.transmit_ready);
    chk1("complete in frame", 1'b0, s.transfer_complete);
    ev("ss");
    get_sr;
    chk1("complete after stop", 1'b1, s.transfer_complete);
    ev("ld", 8'ha5);
    get_sr;
    chk1("rx ready", 1'b1, s.receive_ready);
    chk1("no overrun", 1'b0, s.receive_overrun);
    ev("ld", 8'h5a);
    get_sr;
    chk1("overrun", 1'b1, s.receive_overrun);
    rd_reg(twcs_pkg::A_RHR);
    chk32("rx data", 32'h5a, d);
    get_sr;
    chk1("rx ready read", 1'b0, s.receive_ready);
    chk1("overrun read", 1'b0, s.receive_overrun);
    fin("master");
  endtask

  task automatic t_fault;
    ev("st");
    wr_reg(twcs_pkg::A_THR, 32'h66);
    ev("nk");
    get_sr;
    chk32("nack set", 32'h7, {29'h0, s.not_ack, s.transfer_complete, s.transmit_ready});
    get_sr;
    chk1("nack read", 1'b0, s.not_ack);
    ev("tk");
    ev("st");
    ev("ab");
    get_sr;
    chk32("arb lost", 32'h3, {30'h0, s.arbitration_lost, s.transfer_complete});
    get_sr;
    chk1("arb read", 1'b0, s.arbitration_lost);
    fin("fault");
  endtask

  task automatic t_slave;
    wr_reg(twcs_pkg::A_MODE, 32'h2);
    chk32("enables", 32'h2, {30'h0, sen, men});
    wr_reg(twcs_pkg::A_OWN_SLAVE_ADDRESS, 32'h00550000);
    chk32("own address", 32'h55, {25'h0, own});
    ev("st");
    get_sr;
    chk1("slave start", 1'b0, s.transfer_complete);
    ev("mr");
    ev("gc");
    get_sr;
    chk32("read access", 32'h7, {29'h0, s.slave_access, s.slave_read_direction,
      s.general_call_seen});
    get_sr;
    chk1("gcall read", 1'b0, s.general_call_seen);
    far.due <= 1'b1;
    repeat (3) @(posedge i_mclk);
    #1;
    chk1("scl stretched", 1'b1, scl_oe);
    get_sr;
    chk1("wait state", 1'b1, s.clock_wait_state);
    wr_reg(twcs_pkg::A_THR, 32'h3c);
    far.due <= 1'b0;
    ev("tk");
    get_sr;
    chk1("ready before ack", 1'b0, s.transmit_ready);
    ev("ak");
    ev("nk");
    get_sr;
    chk32("slave nack", 32'h6, {29'h0, s.transmit_ready, s.not_ack, s.slave_access});
    chk1("eos on nack", 1'b1, s.end_of_slave_access);
    chk1("halt", 1'b1, tx.halt);
    ev("st");
    ev("mw");
    get_sr;
    chk32("write access", 32'h2, {30'h0, s.slave_access, s.slave_read_direction});
    ev("sp");
    get_sr;
    chk32("stop", 32'h3, {29'h0, s.slave_access, s.end_of_slave_access,
      s.transfer_complete});
    ev("st");
    ev("rn");
    get_sr;
    chk1("restart no match", 1'b1, s.transfer_complete);
    fin("slave");
  endtask

  task automatic t_count;
    wr_reg(twcs_pkg::A_RCR, 32'h1);
    wr_reg(twcs_pkg::A_RNCR, 32'h0);
    wr_reg(twcs_pkg::A_TCR, 32'h1);
    get_sr;
    chk32("counts set", 32'h0, {28'h0, s[15:12]});
    ev("ld", 8'h11);
    get_sr;
    chk32("rx drained", 32'h5, {28'h0, s[15:12]});
    rd_reg(twcs_pkg::A_RHR);
    for (int z = 0; z < 4; z++)
    begin
      wr_reg(twcs_pkg::A_MODE, {22'h0, z[1:0], 8'h02});
      wr_reg(twcs_pkg::A_SLAVE_INTERNAL_ADDRESS, 32'h00123456);
      chk32("size", {30'h0, z[1:0]}, {30'h0, int_size});
      chk32("int addr", 32'h00123456 & ((32'h1 << (8 * z)) - 32'h1), {8'h0, int_addr});
    end
    fin("count");
  endtask

  task automatic t_irq;
    wr_reg(twcs_pkg::A_IMASK, 32'h0);
    ev("ld", 8'h22);
    @(posedge i_mclk) #1;
    chk1("irq masked", 1'b0, irq);
    wr_reg(twcs_pkg::A_IMASK, 32'h2);
    @(posedge i_mclk) #1;
    chk1("irq raised", 1'b1, irq);
    rd_reg(twcs_pkg::A_RHR);
    @(posedge i_mclk) #1;
    chk1("irq cleared", 1'b0, irq);
    fin("irq");
  endtask

  initial
  begin
    #400000;
    n_errors++;
    $display("unexpected watchdog: expected finish, seen timeout");
    test_done;
  end

  initial
  begin
    i_rst_n = 1'b0;
    addr = '0;
    wdata = '0;
    wr = 1'b0;
    rd = 1'b0;
    repeat (20) @(posedge i_mclk);
    i_rst_n <= 1'b1;
    t_reset;
    t_protect;
    t_scl;
    t_master;
    t_fault;
    t_slave;
    t_count;
    t_irq;
    test_done;
  end
endmodule
